// ==== inc/vif_pkg.sv ====
// constants and types shared by the video input fader
package vif_pkg;
  localparam logic [7:0]  BLACK_Y      = 8'h10;
  localparam logic [7:0]  RGB_MIN      = 8'h00;
  localparam logic [23:0] TRS_PREFIX   = 24'hff0000;
  localparam int          H_BIT        = 4;
  localparam logic [5:0]  FADE_MAX     = 6'h3f;
  localparam logic [5:0]  FADE_HALF    = 6'h1f;
  localparam int          Y_LSB        = 16;
  localparam int          CB_LSB       = 8;
  localparam int          CR_LSB       = 0;
  localparam logic [1:0]  PH_CB        = 2'h0;
  localparam logic [1:0]  PH_CR        = 2'h2;
  localparam int          ACT_BYTES    = 1440;
  localparam int          BAR_STEPS    = 8;
  localparam int          BAR_BYTES    = ACT_BYTES / BAR_STEPS;
  // 75% bars, {y, cb, cr}
  localparam logic [23:0] BAR_TABLE [BAR_STEPS] = '{
    24'hb48080, 24'ha22c8e, 24'h839c2c, 24'h70483a,
    24'h54b8c6, 24'h4164d4, 24'h23d472, 24'h108080};

  typedef struct packed {
    logic [5:0]  fade_a;
    logic [5:0]  fade_b;
    logic [5:0]  fade_c;
    logic [23:0] key_al;
    logic [23:0] key_au;
    logic [23:0] key_bl;
    logic [23:0] key_bu;
    logic [23:0] lut;
  } vif_cfg_t;
endpackage : vif_pkg

// ==== inc/vif_link_if.sv ====
// byte pair handed from the pixel-clock capture to the fader
interface vif_link_if;
  logic       valid;
  logic [7:0] first;
  logic [7:0] second;
  modport src (output valid, output first, output second);
  modport dst (input valid, input first, input second);
endinterface : vif_link_if

// ==== core/vif_blend.sv ====
// one fader blend: factor 0 gives in1, factor 63 gives in2
module vif_blend (
  // operands
  input  wire logic [7:0] i_in1,
  input  wire logic [7:0] i_in2,
  input  wire logic [5:0] i_factor,
  // result
  output logic      [7:0] o_out
);
  logic [13:0] acc;

  always_comb begin
    acc = 14'(vif_pkg::FADE_MAX - i_factor) * 14'(i_in1)
        + 14'(i_factor) * 14'(i_in2)
        + 14'(vif_pkg::FADE_HALF);
    // exact division keeps both ends lossless
    o_out = 8'(acc / 14'(vif_pkg::FADE_MAX));
  end
endmodule : vif_blend

// ==== core/vif_capture.sv ====
// dual-edge pixel port capture, cross switch and crossing to i_clk
module vif_capture #(
  parameter int AW = 2
) (
  // clocks and reset
  input  wire logic   i_clk,
  input  wire logic   i_resetn,
  input  wire logic   i_link_clk,
  // pixel port and switch
  input  wire logic [7:0] i_pix_data,
  input  wire logic   i_edge_first,
  input  wire logic   i_edge_second,
  // captured pairs
  vif_link_if.src     o_link
);
  localparam int N = 1 << AW;
  logic [7:0]    rise_reg, fall_reg;
  logic [1:0]    esel_s1_reg, esel_s2_reg;
  logic [15:0]   bank_reg [N];
  logic [AW-1:0] wbin_reg, wbin_next, wgray_reg, wgray_next;
  logic [AW-1:0] wg_s1_reg, wg_s2_reg, rbin_reg, rbin_next;
  logic [15:0]   pair;
  logic [7:0]    first_reg, first_next, second_reg, second_next;
  logic          valid_reg, valid_next;

  // link side: one stream per edge
  always_ff @(posedge i_link_clk or negedge i_resetn) begin
    if (!i_resetn) rise_reg <= 8'h00;
    else rise_reg <= i_pix_data;
  end
  always_ff @(negedge i_link_clk or negedge i_resetn) begin
    if (!i_resetn) fall_reg <= 8'h00;
    else fall_reg <= i_pix_data;
  end

  always_comb begin
    pair = 16'h0000;
    pair[15:8] = esel_s2_reg[0] ? fall_reg : rise_reg;
    pair[7:0]  = esel_s2_reg[1] ? fall_reg : rise_reg;
    wbin_next  = wbin_reg + AW'(1);
    wgray_next = wbin_next ^ (wbin_next >> 1);
  end

  always_ff @(posedge i_link_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      esel_s1_reg <= 2'h0;
      esel_s2_reg <= 2'h0;
      wbin_reg    <= '0;
      wgray_reg   <= '0;
      for (int i = 0; i < N; i++) bank_reg[i] <= 16'h0000;
    end else begin
      esel_s1_reg        <= {i_edge_second, i_edge_first};
      esel_s2_reg        <= esel_s1_reg;
      bank_reg[wbin_reg] <= pair;
      wbin_reg           <= wbin_next;
      wgray_reg          <= wgray_next;
    end
  end

  // the reader runs faster than the link, so the ring never overruns
  always_comb begin
    rbin_next   = rbin_reg;
    valid_next  = 1'b0;
    first_next  = first_reg;
    second_next = second_reg;
    if ((rbin_reg ^ (rbin_reg >> 1)) != wg_s2_reg) begin
      {first_next, second_next} = bank_reg[rbin_reg];
      valid_next = 1'b1;
      rbin_next  = rbin_reg + AW'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wg_s1_reg  <= '0;
      wg_s2_reg  <= '0;
      rbin_reg   <= '0;
      valid_reg  <= 1'b0;
      first_reg  <= 8'h00;
      second_reg <= 8'h00;
    end else begin
      wg_s1_reg  <= wgray_reg;
      wg_s2_reg  <= wg_s1_reg;
      rbin_reg   <= rbin_next;
      valid_reg  <= valid_next;
      first_reg  <= first_next;
      second_reg <= second_next;
    end
  end

  assign o_link.valid  = valid_reg;
  assign o_link.first  = first_reg;
  assign o_link.second = second_reg;

  a_cross_switch: assert property (@(posedge i_link_clk)
    disable iff (!i_resetn)
    esel_s2_reg[0] |-> pair[15:8] == fall_reg)
    else $error("first stream not taken from falling edge");
endmodule : vif_capture

// ==== core/vif_fader_top.sv ====
// video input fader: dual stream port, keyed fader, routing, colour bars
module vif_fader_top (
  // clocks and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_pixel_port_clock,
  // pixel port
  input  wire logic [7:0]  i_pix_data,
  // stream and mode control
  input  wire logic        i_edge_select_first,
  input  wire logic        i_edge_select_second,
  input  wire logic        i_slave_mode,
  input  wire logic        i_embedded_timing_detect_en,
  input  wire logic        i_std_ntsc,
  // fader control
  input  wire logic        i_fader_en,
  input  wire logic        i_ignore_keys,
  input  wire logic        i_const_fade_mpeg_side,
  input  wire logic        i_const_fade_video_side,
  input  wire logic        i_rgb_source_select,
  input  wire logic        i_encoder_source_select,
  input  wire logic        i_colour_bar_en,
  // fader parameters, taken on i_cfg_load
  input  wire logic        i_cfg_load,
  input  wire logic [5:0]  i_fade_factor_keyed,
  input  wire logic [5:0]  i_fade_factor_table_colour,
  input  wire logic [5:0]  i_fade_factor_unkeyed,
  input  wire logic [23:0] i_key_a_lower,
  input  wire logic [23:0] i_key_a_upper,
  input  wire logic [23:0] i_key_b_lower,
  input  wire logic [23:0] i_key_b_upper,
  input  wire logic [23:0] i_colour_lookup_table,
  // outputs
  output logic [7:0]       o_rgb_data,
  output logic [7:0]       o_enc_data,
  output logic             o_data_valid,
  output logic             o_std_pal
);
  vif_link_if link ();

  vif_capture u_capture (
    .i_clk         (i_clk),
    .i_resetn      (i_resetn),
    .i_link_clk    (i_pixel_port_clock),
    .i_pix_data    (i_pix_data),
    .i_edge_first  (i_edge_select_first),
    .i_edge_second (i_edge_select_second),
    .o_link        (link)
  );

  function automatic logic [7:0] pick(input logic [23:0] c,
                                      input logic [1:0]  ph);
    if (ph == vif_pkg::PH_CB) return c[vif_pkg::CB_LSB +: 8];
    if (ph == vif_pkg::PH_CR) return c[vif_pkg::CR_LSB +: 8];
    return c[vif_pkg::Y_LSB +: 8];
  endfunction : pick

  function automatic logic inside_win(input logic [23:0] c,
                                      input logic [23:0] lo,
                                      input logic [23:0] hi);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 24; i += 8) begin
      if (c[i +: 8] < lo[i +: 8] || c[i +: 8] > hi[i +: 8]) ok = 1'b0;
    end
    return ok;
  endfunction : inside_win

  vif_pkg::vif_cfg_t cfg_reg, cfg_next;
  logic        det_en;
  logic [1:0]  code_hit, sav_hit, pass_bit;
  logic [1:0]  phase0;
  logic [7:0]  raw [2];
  logic [10:0] cnt_reg, cnt_next;
  logic [23:0] comp_reg, comp_next, cur;
  logic [2:0]  bar_idx;
  logic [7:0]  mpeg_b, video_b, lut_b, in1, in2, blend_out, fader_out;
  logic [5:0]  fsel;
  logic        key_a, key_b;
  logic [7:0]  rgb_reg, rgb_next, enc_reg, enc_next;
  logic        dv_reg, pal_reg;

  assign raw[0] = link.first;
  assign raw[1] = link.second;
  assign det_en = i_slave_mode && i_embedded_timing_detect_en;

  // per-stream timing code watch and component phase
  for (genvar s = 0; s < 2; s++) begin : g_stream
    logic [23:0] hist_reg, hist_next;
    logic [1:0]  phase_reg, phase_next;
    logic        pass_reg, pass_next;

    // relies on the source keeping ff 00 00 out of active data
    assign code_hit[s] = det_en && hist_reg == vif_pkg::TRS_PREFIX;
    assign sav_hit[s]  = code_hit[s] && !raw[s][vif_pkg::H_BIT];
    assign pass_bit[s] = pass_reg;

    always_comb begin
      hist_next  = hist_reg;
      phase_next = phase_reg;
      pass_next  = pass_reg && det_en;
      if (link.valid) begin
        hist_next = {hist_reg[15:0], raw[s]};
        if (code_hit[s]) begin
          phase_next = 2'h0;
          pass_next  = sav_hit[s];
        end else begin
          phase_next = phase_reg + 2'h1;
        end
      end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        hist_reg  <= 24'h000000;
        phase_reg <= 2'h0;
        pass_reg  <= 1'b0;
      end else begin
        hist_reg  <= hist_next;
        phase_reg <= phase_next;
        pass_reg  <= pass_next;
      end
    end

    if (s == 0) begin : g_ph
      assign phase0 = phase_reg;
    end
  end

  // data manager: bar position restarts at each start code on the first stream
  always_comb begin
    cnt_next = cnt_reg;
    if (link.valid) begin
      if (sav_hit[0] || cnt_reg == 11'(vif_pkg::ACT_BYTES - 1))
        cnt_next = 11'h000;
      else
        cnt_next = cnt_reg + 11'h001;
    end
    bar_idx = 3'(cnt_reg / 11'(vif_pkg::BAR_BYTES));
  end

  always_comb begin
    if (i_colour_bar_en) begin
      mpeg_b  = pick(vif_pkg::BAR_TABLE[bar_idx], phase0);
      video_b = mpeg_b;
    end else begin
      mpeg_b  = raw[0];
      video_b = raw[1];
    end
    lut_b = pick(cfg_reg.lut, phase0);
    cur = comp_reg;
    if (phase0 == vif_pkg::PH_CB) cur[vif_pkg::CB_LSB +: 8] = mpeg_b;
    else if (phase0 == vif_pkg::PH_CR) cur[vif_pkg::CR_LSB +: 8] = mpeg_b;
    else cur[vif_pkg::Y_LSB +: 8] = mpeg_b;
    comp_next = link.valid ? cur : comp_reg;
    key_a = inside_win(cur, cfg_reg.key_al, cfg_reg.key_au);
    key_b = inside_win(cur, cfg_reg.key_bl, cfg_reg.key_bu);
  end

  // factor and operand choice; earlier arms take priority
  always_comb begin
    in1  = mpeg_b;
    in2  = video_b;
    fsel = cfg_reg.fade_c;
    if (pass_bit[0]) begin
      fsel = 6'h00;
    end else if (pass_bit[1]) begin
      fsel = vif_pkg::FADE_MAX;
    end else if (i_ignore_keys || i_const_fade_video_side) begin
      in1  = lut_b;
      fsel = cfg_reg.fade_b;
    end else if (i_const_fade_mpeg_side) begin
      in1  = lut_b;
      in2  = mpeg_b;
      fsel = cfg_reg.fade_b;
    end else if (key_a) begin
      fsel = cfg_reg.fade_a;
    end else if (key_b) begin
      in1  = lut_b;
      fsel = cfg_reg.fade_b;
    end
  end

  vif_blend u_blend (
    .i_in1    (in1),
    .i_in2    (in2),
    .i_factor (fsel),
    .o_out    (blend_out)
  );

  always_comb begin
    // an idle fader hands the first stream straight through
    fader_out = i_fader_en ? blend_out : mpeg_b;
    rgb_next  = rgb_reg;
    enc_next  = enc_reg;
    if (link.valid) begin
      rgb_next = i_rgb_source_select ? fader_out : video_b;
      enc_next = i_encoder_source_select ? fader_out : video_b;
    end
    cfg_next = cfg_reg;
    if (i_cfg_load)
      cfg_next = '{i_fade_factor_keyed, i_fade_factor_table_colour,
                   i_fade_factor_unkeyed, i_key_a_lower, i_key_a_upper,
                   i_key_b_lower, i_key_b_upper, i_colour_lookup_table};
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_reg  <= '0;
      cnt_reg  <= 11'h000;
      comp_reg <= 24'h000000;
      rgb_reg  <= vif_pkg::RGB_MIN;
      enc_reg  <= vif_pkg::BLACK_Y;
      dv_reg   <= 1'b0;
      pal_reg  <= 1'b1;
    end else begin
      cfg_reg  <= cfg_next;
      cnt_reg  <= cnt_next;
      comp_reg <= comp_next;
      rgb_reg  <= rgb_next;
      enc_reg  <= enc_next;
      dv_reg   <= link.valid;
      pal_reg  <= !i_std_ntsc;
    end
  end

  assign o_rgb_data   = rgb_reg;
  assign o_enc_data   = enc_reg;
  assign o_data_valid = dv_reg;
  assign o_std_pal    = pal_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_rgb_fader_path: assert property (link.valid && i_rgb_source_select
    |=> o_rgb_data == $past(fader_out))
    else $error("rgb path did not take fader output");
  a_rgb_direct: assert property (link.valid && !i_rgb_source_select
    |=> o_rgb_data == $past(video_b))
    else $error("rgb path did not take second stream");
  a_enc_route: assert property (link.valid
    |=> o_enc_data == ($past(i_encoder_source_select) ?
                       $past(fader_out) : $past(video_b)))
    else $error("encoder path source wrong");
  a_blend_low_end: assert property (fsel == 6'h00
    |-> blend_out == in1)
    else $error("code zero did not give first input");
  a_blend_high_end: assert property (fsel == vif_pkg::FADE_MAX
    |-> blend_out == in2)
    else $error("code 3f did not give second input");
  a_timing_gate: assert property (!det_en ##1 !det_en
    |-> pass_bit == 2'b00 && code_hit == 2'b00)
    else $error("timing code acted outside slave detect mode");
  a_pass_full: assert property (pass_bit[0]
    |-> fsel == 6'h00 && in1 == mpeg_b)
    else $error("start code did not force full weight");
  a_unkeyed_sel: assert property (!pass_bit[0] && !pass_bit[1]
    && !i_ignore_keys && !i_const_fade_video_side
    && !i_const_fade_mpeg_side && !key_a && !key_b
    |-> fsel == cfg_reg.fade_c && in1 == mpeg_b)
    else $error("unkeyed factor not chosen");
  a_bar_restart: assert property (link.valid && sav_hit[0]
    |=> cnt_reg == 11'h000 ##0 bar_idx == 3'h0)
    else $error("bar sequence did not restart at line start");
  a_pal_follow: assert property (!i_std_ntsc [*2]
    |-> o_std_pal)
    else $error("standard select not reflected");

  c_key_a_hit: cover property (link.valid && key_a && i_fader_en);
  c_sav_seen: cover property (link.valid && sav_hit[0]);
  c_bars_on: cover property (o_data_valid && i_colour_bar_en);
  c_lut_fade: cover property (link.valid && key_b && !key_a);
endmodule : vif_fader_top

// ==== verif/vif_pix_src.sv ====
// pixel source model: free running pixel clock and dual-edge byte streams
module vif_pix_src (
  // generated pixel port
  output logic       o_clk,
  output logic [7:0] o_data,
  // bytes sent for each edge
  input  wire logic [7:0] i_rise_byte,
  input  wire logic [7:0] i_fall_byte
);
  timeunit 1ns;
  timeprecision 100ps;

  // odd start offset keeps the pixel clock out of phase with i_clk
  initial begin
    o_clk  = 1'b0;
    o_data = 8'h5a;
    #3.3;
    forever #7.5 o_clk = ~o_clk;
  end

  // data moves a quarter period after each edge, stable at the next one
  always @(posedge o_clk) o_data <= #3.75 i_fall_byte;
  always @(negedge o_clk) o_data <= #3.75 i_rise_byte;
endmodule : vif_pix_src

// ==== verif/vif_fader_top_tb.sv ====
// self-checking bench for the video input fader
module vif_fader_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        i_clk     = 1'b0;
  logic        i_resetn  = 1'b0;
  logic        pix_clk;
  logic [7:0]  pix_data;
  logic [7:0]  rise_byte = 8'h40;
  logic [7:0]  fall_byte = 8'h80;
  logic        es_f = 1'b0, es_s = 1'b0, slave = 1'b0, ts_en = 1'b0;
  logic        ntsc = 1'b0, fen = 1'b0, ign = 1'b0, cfm = 1'b0;
  logic        cfv = 1'b0, rgb_sel = 1'b0, enc_sel = 1'b0, bar = 1'b0;
  logic        load = 1'b0;
  logic [5:0]  fa = 6'h00, fb = 6'h00, fc = 6'h00;
  logic [23:0] kal = 24'h0, kau = 24'h0, kbl = 24'h0, kbu = 24'h0;
  logic [23:0] lut = 24'h0;
  logic [7:0]  o_rgb_data;
  logic [7:0]  o_enc_data;
  logic        o_data_valid;
  logic        o_std_pal;
  int          error_cnt = 0;
  int          n_tests   = 0;
  int          seed      = 6;

  always #5 i_clk = ~i_clk;

  vif_pix_src vif_pix_src_i (
    .o_clk       (pix_clk),
    .o_data      (pix_data),
    .i_rise_byte (rise_byte),
    .i_fall_byte (fall_byte)
  );

  vif_fader_top vif_fader_top_i (
    .i_clk                       (i_clk),
    .i_resetn                    (i_resetn),
    .i_pixel_port_clock          (pix_clk),
    .i_pix_data                  (pix_data),
    .i_edge_select_first         (es_f),
    .i_edge_select_second        (es_s),
    .i_slave_mode                (slave),
    .i_embedded_timing_detect_en (ts_en),
    .i_std_ntsc                  (ntsc),
    .i_fader_en                  (fen),
    .i_ignore_keys               (ign),
    .i_const_fade_mpeg_side      (cfm),
    .i_const_fade_video_side     (cfv),
    .i_rgb_source_select         (rgb_sel),
    .i_encoder_source_select     (enc_sel),
    .i_colour_bar_en             (bar),
    .i_cfg_load                  (load),
    .i_fade_factor_keyed         (fa),
    .i_fade_factor_table_colour  (fb),
    .i_fade_factor_unkeyed       (fc),
    .i_key_a_lower               (kal),
    .i_key_a_upper               (kau),
    .i_key_b_lower               (kbl),
    .i_key_b_upper               (kbu),
    .i_colour_lookup_table       (lut),
    .o_rgb_data                  (o_rgb_data),
    .o_enc_data                  (o_enc_data),
    .o_data_valid                (o_data_valid),
    .o_std_pal                   (o_std_pal)
  );

  task automatic report_and_stop();
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // random byte that never looks like a timing code
  function automatic logic [7:0] rb();
    return 8'(1 + ($random(seed) & 32'hff) % 254);
  endfunction : rb

  function automatic logic [7:0] blend(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic [5:0] f);
    int s;
    s = (63 - f) * a + f * b + 31;
    return 8'(s / 63);
  endfunction : blend

  // keys and table colour use equal components so every phase agrees
  function automatic logic [7:0] exp_fade(input logic [7:0] m,
                                          input logic [7:0] v);
    if (!fen) return m;
    if (ign || cfv) return blend(lut[7:0], v, fb);
    if (cfm) return blend(lut[7:0], m, fb);
    if (m >= kal[7:0] && m <= kau[7:0]) return blend(m, v, fa);
    if (m >= kbl[7:0] && m <= kbu[7:0]) return blend(lut[7:0], v, fb);
    return blend(m, v, fc);
  endfunction : exp_fade

  function automatic logic is_bar(input logic [7:0] x);
    for (int i = 0; i < vif_pkg::BAR_STEPS; i++)
      for (int c = 0; c < 24; c += 8)
        if (x === vif_pkg::BAR_TABLE[i][c +: 8]) return 1'b1;
    return 1'b0;
  endfunction : is_bar

  // sampled 1 ns after the edge so the output register has landed
  task automatic wait_valid();
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (o_data_valid !== 1'b1 && n < 20);
    if (o_data_valid !== 1'b1) check(8'h00, 8'h01);
  endtask : wait_valid

  task automatic check_reset();
    @(posedge i_clk);
    i_resetn <= 1'b0;
    @(negedge i_clk);
    check(o_rgb_data, vif_pkg::RGB_MIN);
    check(o_enc_data, vif_pkg::BLACK_Y);
    check({7'h0, o_data_valid}, 8'h00);
    check({7'h0, o_std_pal}, 8'h01);
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
  endtask : check_reset

  task automatic rand_case(input int k);
    logic [7:0] r, f, m, v, hit, miss;
    logic [5:0] c0;
    r = rb();
    f = rb();
    m = es_f ? f : r;
    c0 = k[0] ? vif_pkg::FADE_MAX : 6'h00;
    @(posedge i_clk);
    rise_byte <= r;
    fall_byte <= f;
    {slave, ts_en, ntsc, rgb_sel, enc_sel} <= 5'($random(seed));
    fen <= ($random(seed) & 3) != 0;
    ign <= ($random(seed) & 3) == 0;
    cfm <= ($random(seed) & 3) == 0;
    cfv <= ($random(seed) & 3) == 0;
    fa  <= (k < 8) ? c0 : 6'($random(seed));
    fb  <= (k < 8) ? c0 : 6'($random(seed));
    fc  <= (k < 8) ? c0 : 6'($random(seed));
    lut <= {3{rb()}};
    m   = (($random(seed) & 1) != 0) ? f : r;
    es_f <= (m == f);
    es_s <= ($random(seed) & 1) != 0;
    hit  = m;
    miss = m + 8'h01;
    // inclusive bounds: a window of one value tests both edges at once
    kal <= {3{(k % 4 == 0 || k % 4 == 3) ? hit : miss}};
    kau <= {3{(k % 4 == 0 || k % 4 == 3) ? hit : miss}};
    kbl <= {3{(k % 4 == 1 || k % 4 == 3) ? hit : miss}};
    kbu <= {3{(k % 4 == 1 || k % 4 == 3) ? hit : miss}};
    load <= 1'b1;
    @(posedge i_clk);
    load <= 1'b0;
    repeat (30) @(posedge i_clk);
    wait_valid();
    m = es_f ? fall_byte : rise_byte;
    v = es_s ? fall_byte : rise_byte;
    f = exp_fade(m, v);
    check(o_rgb_data, rgb_sel ? f : v);
    check(o_enc_data, enc_sel ? f : v);
    check({7'h0, o_std_pal}, {7'h0, !ntsc});
  endtask : rand_case

  // ff 00 00 xy on one stream only, then plain data on both streams
  task automatic code_case(input logic [7:0] xy, input logic on_first);
    logic [7:0] seq [4];
    logic [7:0] e;
    seq = '{8'hff, 8'h00, 8'h00, xy};
    for (int i = 0; i < 4; i++) begin
      @(posedge pix_clk);
      if (on_first) rise_byte <= seq[i];
      else fall_byte <= seq[i];
    end
    @(posedge pix_clk);
    rise_byte <= 8'h31;
    fall_byte <= 8'hc4;
    repeat (30) @(posedge i_clk);
    wait_valid();
    // a start code forces full weight of its own stream until the next code
    e = xy[vif_pkg::H_BIT] ? blend(8'h31, 8'hc4, fc)
                           : (on_first ? 8'h31 : 8'hc4);
    check(o_rgb_data, e);
    check(o_enc_data, 8'hc4);
  endtask : code_case

  task automatic bar_case();
    logic [7:0] seen;
    seen = 8'h00;
    @(posedge i_clk);
    {bar, fen, rgb_sel, enc_sel, slave, ts_en} <= 6'b100100;
    repeat (30) @(posedge i_clk);
    repeat (vif_pkg::ACT_BYTES + 40) begin
      wait_valid();
      check({7'h0, is_bar(o_rgb_data)}, 8'h01);
      check({7'h0, is_bar(o_enc_data)}, 8'h01);
      for (int i = 0; i < vif_pkg::BAR_STEPS; i++)
        if (o_rgb_data === vif_pkg::BAR_TABLE[i][23:16]) seen[i] = 1'b1;
    end
    check(seen, 8'hff);
    @(posedge i_clk);
    bar <= 1'b0;
  endtask : bar_case

  initial begin
    #200us;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    check_reset();
    for (int k = 0; k < 40; k++) rand_case(k);
    bar_case();
    // embedded timing codes: first stream on rise edge, second on fall edge
    @(posedge i_clk);
    {fen, rgb_sel, enc_sel, ign, cfm, cfv, slave, ts_en} <= 8'hc3;
    es_f <= 1'b0;
    es_s <= 1'b1;
    fc   <= 6'h2a;
    {kal, kau, kbl, kbu} <= {12{8'hfe}};
    rise_byte <= 8'h31;
    fall_byte <= 8'hc4;
    load <= 1'b1;
    @(posedge i_clk);
    load <= 1'b0;
    code_case(8'h80, 1'b1);
    code_case(8'h9d, 1'b1);
    code_case(8'hab, 1'b0);
    code_case(8'hb6, 1'b0);
    @(posedge i_clk);
    slave <= 1'b0;
    check_reset();
    for (int k = 40; k < 48; k++) rand_case(k);
    report_and_stop();
  end
endmodule : vif_fader_top_tb
